// file: hws_pkg.sv
// package: constants and carrier types for the host wakeup signalling block
`default_nettype none
package hws_pkg;
  // =====================================================================
  // time bases
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_S;
  localparam int          MS_CNT_W      = 17;
  localparam int          S_CNT_W       = 10;
  localparam logic [MS_CNT_W-1:0] MS_TICK_LAST =
    MS_CNT_W'(CYC_PER_MS - 1);
  localparam logic [S_CNT_W-1:0]  S_TICK_LAST  =
    S_CNT_W'(MS_PER_S - 1);
  // =====================================================================
  // setting widths and reset values
  localparam int LEAD_W   = 16;
  localparam int WINDOW_W = 16;
  localparam logic [LEAD_W-1:0]   LEAD_OFF     = 16'h0000;
  localparam logic [WINDOW_W-1:0] WINDOW_ZERO  = 16'h0000;
  localparam logic [LEAD_W-1:0]   LEAD_ONE     = 16'h0001;
  localparam logic [WINDOW_W-1:0] WINDOW_ONE   = 16'h0001;
  // =====================================================================
  // carriers
  typedef struct packed {
    logic [LEAD_W-1:0]   wake_lead_delay_ms;
    logic [WINDOW_W-1:0] min_wake_window_s;
  } hws_cfg_t;

  typedef struct packed {
    logic data_pending;
    logic tx_active;
    logic rx_active;
  } hws_uart_t;

  typedef enum logic [1:0] {
    HWS_IDLE  = 2'b00,
    HWS_LEAD  = 2'b01,
    HWS_SEND  = 2'b10,
    HWS_AWAKE = 2'b11
  } hws_state_t;
endpackage
`default_nettype wire

// file: hws_tick_gen.sv
// module: millisecond and second strobes derived from the system clock
`timescale 1ns/10ps
`default_nettype none
module hws_tick_gen (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // strobes
  output logic      ms_tick_out,
  output logic      s_tick_out
);
  import hws_pkg::*;

  logic [MS_CNT_W-1:0] ms_cnt_ff;
  logic [MS_CNT_W-1:0] nxt_ms_cnt;
  logic [S_CNT_W-1:0]  s_cnt_ff;
  logic [S_CNT_W-1:0]  nxt_s_cnt;
  logic                ms_tick_ff;
  logic                nxt_ms_tick;
  logic                s_tick_ff;
  logic                nxt_s_tick;

  // =====================================================================
  // free running dividers
  always_comb begin
    nxt_ms_tick = (ms_cnt_ff == MS_TICK_LAST);
    nxt_ms_cnt  = nxt_ms_tick ? '0 : ms_cnt_ff + MS_CNT_W'(1'b1);
    nxt_s_cnt   = s_cnt_ff;
    nxt_s_tick  = 1'b0;
    if (nxt_ms_tick) begin
      nxt_s_tick = (s_cnt_ff == S_TICK_LAST);
      nxt_s_cnt  = nxt_s_tick ? '0 : s_cnt_ff + S_CNT_W'(1'b1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ms_cnt_ff  <= '0;
      s_cnt_ff   <= '0;
      ms_tick_ff <= 1'b0;
      s_tick_ff  <= 1'b0;
    end else begin
      ms_cnt_ff  <= nxt_ms_cnt;
      s_cnt_ff   <= nxt_s_cnt;
      ms_tick_ff <= nxt_ms_tick;
      s_tick_ff  <= nxt_s_tick;
    end
  end

  assign ms_tick_out = ms_tick_ff;
  assign s_tick_out  = s_tick_ff;
endmodule // hws_tick_gen
`default_nettype wire

// file: hws_wakeup.sv
// module: active-low host wake line control with lead delay and wake window
`timescale 1ns/10ps
`default_nettype none
// How it works
// - wake line goes low when data for the host is pending.
// - after going low, wait the lead delay in ms before sending.
// - lead delay zero is reset default and disables the wake line.
// - sending after a wake drop starts only after lead delay; flow control still gates bytes.
// - wake line stays low while sending is in progress.
// - wake line returns high once pending data is all sent.
// - second setting in seconds gives the minimum wake window.
// - window restarts on any serial traffic in either direction.
// - no new wake assertion while the window is still running.
module hws_wakeup (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // settings
  input  wire hws_pkg::hws_cfg_t  cfg_in,
  // serial engine status
  input  wire hws_pkg::hws_uart_t uart_in,
  // to serial engine
  output logic                  tx_enable_out,
  // host pin
  output logic                  host_wake_out_n,
  output logic                  window_open_out
);
  import hws_pkg::*;

  logic              s_tick;
  hws_state_t        state_ff;
  hws_state_t        nxt_state;
  logic [LEAD_W-1:0] lead_cnt_ff;
  logic [LEAD_W-1:0] nxt_lead_cnt;
  logic [WINDOW_W-1:0] win_cnt_ff;
  logic [WINDOW_W-1:0] nxt_win_cnt;
  logic [MS_CNT_W-1:0] lead_sub_ff;
  logic [MS_CNT_W-1:0] nxt_lead_sub;
  logic              lead_tick;
  logic              win_skip_ff;
  logic              nxt_win_skip;
  logic              wake_n_ff;
  logic              nxt_wake_n;
  logic              tx_en_ff;
  logic              nxt_tx_en;
  logic              win_ff;
  logic              nxt_win;
  logic              traffic;
  logic              enabled;

  // =====================================================================
  // time bases
  hws_tick_gen u_ticks (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .ms_tick_out (),
    .s_tick_out  (s_tick)
  );

  assign traffic = uart_in.tx_active | uart_in.rx_active;
  assign enabled = (cfg_in.wake_lead_delay_ms != LEAD_OFF);
  // lead timed from the drop itself: a free running ms strobe could end
  // a one ms lead a single cycle after the line falls
  assign lead_tick = (lead_sub_ff == MS_TICK_LAST);

  // =====================================================================
  // wake sequencing
  always_comb begin
    nxt_state    = state_ff;
    nxt_lead_cnt = lead_cnt_ff;
    nxt_win_cnt  = win_cnt_ff;
    nxt_lead_sub = '0;
    nxt_win_skip = win_skip_ff;
    nxt_wake_n   = 1'b1;
    nxt_tx_en    = 1'b0;
    // window timed from last traffic; restarted by any byte
    if (traffic) begin
      nxt_win_cnt  = cfg_in.min_wake_window_s;
      nxt_win_skip = 1'b1;
    end else if (s_tick && win_skip_ff) begin
      // first s strobe after traffic is a partial second; skipping it
      // keeps the window at least as long as the setting
      nxt_win_skip = 1'b0;
    end else if (s_tick && win_cnt_ff != WINDOW_ZERO) begin
      nxt_win_cnt = win_cnt_ff - WINDOW_ONE;
    end
    case (state_ff)
      HWS_IDLE: begin
        if (!enabled) begin
          nxt_tx_en = 1'b1;
        end else if (uart_in.data_pending) begin
          if (win_cnt_ff != WINDOW_ZERO) begin
            nxt_state = HWS_AWAKE;
            nxt_tx_en = 1'b1;
          end else begin
            nxt_state    = HWS_LEAD;
            nxt_lead_cnt = cfg_in.wake_lead_delay_ms;
            nxt_wake_n   = 1'b0;
          end
        end
      end
      HWS_LEAD: begin
        nxt_wake_n   = 1'b0;
        nxt_lead_sub = lead_tick ? '0 : lead_sub_ff + MS_CNT_W'(1'b1);
        if (lead_tick) begin
          nxt_lead_cnt = lead_cnt_ff - LEAD_ONE;
        end
        if (lead_tick && lead_cnt_ff == LEAD_ONE) begin
          nxt_state = HWS_SEND;
          nxt_tx_en = 1'b1;
        end
      end
      HWS_SEND: begin
        // line held low until nothing is pending or on the wire
        if (uart_in.data_pending || uart_in.tx_active) begin
          nxt_wake_n = 1'b0;
          nxt_tx_en  = 1'b1;
        end else begin
          nxt_state = HWS_IDLE;
        end
      end
      HWS_AWAKE: begin
        if (uart_in.data_pending || uart_in.tx_active) begin
          nxt_tx_en = 1'b1;
        end else begin
          nxt_state = HWS_IDLE;
        end
      end
      default: begin
        nxt_state = HWS_IDLE;
      end
    endcase
    nxt_win = (nxt_win_cnt != WINDOW_ZERO);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff    <= HWS_IDLE;
      lead_cnt_ff <= LEAD_OFF;
      win_cnt_ff  <= WINDOW_ZERO;
      lead_sub_ff <= '0;
      win_skip_ff <= 1'b0;
      wake_n_ff   <= 1'b1;
      tx_en_ff    <= 1'b0;
      win_ff      <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      lead_cnt_ff <= nxt_lead_cnt;
      win_cnt_ff  <= nxt_win_cnt;
      lead_sub_ff <= nxt_lead_sub;
      win_skip_ff <= nxt_win_skip;
      wake_n_ff   <= nxt_wake_n;
      tx_en_ff    <= nxt_tx_en;
      win_ff      <= nxt_win;
    end
  end

  assign host_wake_out_n = wake_n_ff;
  assign tx_enable_out   = tx_en_ff;
  assign window_open_out = win_ff;

  // =====================================================================
  // checks
  sequence s_wake_drop;
    $fell(host_wake_out_n);
  endsequence

  property p_reset_high;
    @(posedge clk_in) $rose(rst_n_in) |-> host_wake_out_n;
  endproperty
  a_reset_high: assert property (p_reset_high)
    else $error("wake line not high after reset");

  property p_disabled_high;
    @(posedge clk_in) disable iff (!rst_n_in)
    (!enabled && state_ff == HWS_IDLE) |=> host_wake_out_n;
  endproperty
  a_disabled_high: assert property (p_disabled_high)
    else $error("wake line low while mechanism disabled");

  property p_drop_cause;
    @(posedge clk_in) disable iff (!rst_n_in)
    s_wake_drop |-> $past(uart_in.data_pending) && $past(enabled);
  endproperty
  a_drop_cause: assert property (p_drop_cause)
    else $error("wake line dropped with nothing pending");

  property p_no_tx_on_drop;
    @(posedge clk_in) disable iff (!rst_n_in)
    s_wake_drop |-> !tx_enable_out ##1 !tx_enable_out;
  endproperty
  a_no_tx_on_drop: assert property (p_no_tx_on_drop)
    else $error("sending enabled before lead delay");

  property p_tx_after_lead;
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_ff == HWS_LEAD && lead_tick && lead_cnt_ff == LEAD_ONE)
      |=> tx_enable_out && !host_wake_out_n;
  endproperty
  a_tx_after_lead: assert property (p_tx_after_lead)
    else $error("sending not enabled when lead delay expired");

  property p_low_while_send;
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_ff == HWS_SEND && uart_in.tx_active) |=> !host_wake_out_n;
  endproperty
  a_low_while_send: assert property (p_low_while_send)
    else $error("wake line released during transmission");

  property p_release_done;
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_ff == HWS_SEND && !uart_in.data_pending && !uart_in.tx_active)
      |=> host_wake_out_n && !tx_enable_out
          ##1 (host_wake_out_n || !$past(window_open_out));
  endproperty
  a_release_done: assert property (p_release_done)
    else $error("wake line not released after sending");

  property p_window_restart;
    @(posedge clk_in) disable iff (!rst_n_in)
    traffic |=> win_cnt_ff == $past(cfg_in.min_wake_window_s);
  endproperty
  a_window_restart: assert property (p_window_restart)
    else $error("wake window not restarted by traffic");

  property p_no_rewake;
    @(posedge clk_in) disable iff (!rst_n_in)
    (win_cnt_ff != WINDOW_ZERO && state_ff == HWS_IDLE) |=> host_wake_out_n;
  endproperty
  a_no_rewake: assert property (p_no_rewake)
    else $error("wake line asserted inside wake window");

  property p_window_count;
    @(posedge clk_in) disable iff (!rst_n_in)
    (s_tick && !traffic && !win_skip_ff && win_cnt_ff != WINDOW_ZERO)
      |=> win_cnt_ff == $past(win_cnt_ff) - WINDOW_ONE;
  endproperty
  a_window_count: assert property (p_window_count)
    else $error("wake window not counting seconds");

  property p_window_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
    (s_tick && !traffic && win_skip_ff)
      |=> win_cnt_ff == $past(win_cnt_ff) && !win_skip_ff;
  endproperty
  a_window_hold: assert property (p_window_hold)
    else $error("wake window shortened by partial second");
endmodule // hws_wakeup
`default_nettype wire

// file: hws_host_model.sv
// host processor model: wakes on the line, replies once, sleeps when idle
`timescale 1ns/10ps
`default_nettype none
module hws_host_model #(
  parameter int REPLY_DLY  = 20,
  parameter int WINDOW_CYC = 1000
) (
  // clock and wake line
  input  wire logic clk_in,
  input  wire logic host_wake_out_n,
  // serial activity toward the device
  output logic      rx_active_out,
  output logic      awake_out
);
  logic rx_q    = 1'b0;
  logic awake_q = 1'b0;
  int   cnt     = 0;
  int   idle    = 0;

  assign rx_active_out = rx_q;
  assign awake_out     = awake_q;

  // ======================================================================
  // wake and sleep
  // idle count is in cycles, not seconds, so the model sleeps early; the
  // bench never relies on the host staying up longer than that
  always @(posedge clk_in) begin
    if (!host_wake_out_n) begin
      awake_q <= 1'b1;
      idle    <= 0;
    end else if (awake_q) begin
      idle <= idle + 1;
      if (idle >= WINDOW_CYC) begin
        awake_q <= 1'b0;
      end
    end
  end

  // ======================================================================
  // one reply byte a fixed delay after the line drops
  always @(posedge clk_in) begin
    if (host_wake_out_n) begin
      cnt <= 0;
    end else if (cnt <= REPLY_DLY) begin
      cnt <= cnt + 1;
    end
    rx_q <= !host_wake_out_n && (cnt == REPLY_DLY - 1);
  end
endmodule  // hws_host_model
`default_nettype wire

// file: tb_hws_wakeup.sv
// self-checking bench for the host wake line block
`timescale 1ns/10ps
`default_nettype none
module tb_hws_wakeup;
  import hws_pkg::*;
  logic       clk_in   = 1'b0;
  logic       rst_n_in = 1'b0;
  hws_cfg_t   cfg      = '0;
  logic       pend     = 1'b0;
  logic       txa      = 1'b0;
  logic       rxa;
  hws_uart_t  uart;
  logic       tx_en;
  logic       wake_n;
  logic       win;
  logic       awake;
  logic [2:0] exp_q[$];
  int         n_fail     = 0;
  int         num_checks = 0;
  int         cyc;
  event       look;

  assign uart = {pend, txa, rxa};
  always #5 clk_in = ~clk_in;

  hws_wakeup i_hws_wakeup (
    .clk_in         (clk_in),
    .rst_n_in       (rst_n_in),
    .cfg_in         (cfg),
    .uart_in        (uart),
    .tx_enable_out  (tx_en),
    .host_wake_out_n(wake_n),
    .window_open_out(win)
  );

  hws_host_model i_hws_host_model (
    .clk_in         (clk_in),
    .host_wake_out_n(wake_n),
    .rx_active_out  (rxa),
    .awake_out      (awake)
  );

  // ======================================================================
  // checking
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic note(input logic [2:0] exp);
    exp_q.push_back(exp);
    ->look;
  endtask

  // outputs as {wake line, send enable, window open}
  always begin
    @(look);
    chk({wake_n, tx_en, win}, exp_q.pop_front());
  end

  task automatic end_of_test;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ======================================================================
  // driving, always at the falling edge
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic do_reset(input hws_cfg_t c);
    rst_n_in = 1'b0;
    cfg      = c;
    pend     = 1'b0;
    txa      = 1'b0;
    cycles(5);
    rst_n_in = 1'b1;
  endtask

  task automatic burst(input int n, input logic do_note);
    txa = 1'b1;
    repeat (n) begin
      cycles(1);
      if (do_note) begin
        note(3'b011);
      end
    end
    txa = 1'b0;
  endtask

  // ======================================================================
  // watchdog: both tests take about 100100 cycles
  initial begin
    repeat (120000) @(posedge clk_in);
    n_fail++;
    end_of_test;
  end

  // ======================================================================
  // tests
  initial begin
    void'($urandom(32'h141102DB));
    do_reset('{wake_lead_delay_ms: LEAD_OFF, min_wake_window_s: WINDOW_ONE});
    cycles(2);
    note(3'b110);
    pend = 1'b1;
    burst(1 + $urandom % 8, 1'b0);
    cycles(3);
    note(3'b111);
    $display("test lead_off done");

    // second reset lands in mid-run; do_reset clears the data left pending by the first test
    do_reset('{wake_lead_delay_ms: LEAD_ONE, min_wake_window_s: WINDOW_ONE});
    cycles(1);
    pend = 1'b1;
    cycles(2);
    note(3'b000);
    cycles(40);
    note(3'b001);
    chk({2'b00, awake}, 3'b001);
    cyc = 0;
    while (tx_en !== 1'b1 && cyc < 101000) begin
      cycles(1);
      cyc++;
    end
    chk({2'b00, cyc >= 99000 && cyc < 101000}, 3'b001);
    note(3'b011);
    burst(1 + $urandom % 8, 1'b1);
    pend = 1'b0;
    cycles(2);
    note(3'b101);
    pend = 1'b1;
    cycles(2);
    note(3'b111);
    cycles(50);
    note(3'b111);
    $display("test wake_cycle done");
    cycles(1);
    end_of_test;
  end
endmodule  // tb_hws_wakeup
`default_nettype wire
